// *** core/iwrs_device.sv ***
// Overview of operation
// - Byte is eight data bits plus ack
// - Data changes only while clock low
// - Start condition begins address byte shifting
// - Seven-bit address MSB first, then direction
// - Matching address acked, mismatch goes idle
// - Direction 0 writes, 1 reads
// - Master nack ends read, device releases
// - Stop returns device to idle
// - Direction fixed until next start
// - First written byte loads register pointer
// - Word write sends high then low
// - Word read uses repeated start, high first
// - Master acks to continue, nacks to finish
// - Repeated start keeps the register pointer
// - No limit on bytes per operation
// - Master always writes complete words
// - After low byte comes new pointer
module iwrs_device #(
  parameter logic [6:0] SLAVE_ADDR = iwrs_pkg::DEV_ADDR
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic clkLink,
  iwrs_link_if.device link,
  output logic [7:0] regAddr,
  output logic regWe,
  output logic [15:0] regWrData,
  output logic regRe,
  input wire logic [15:0] regRdData
);
  function automatic iwrs_pkg::iwrs_role_e nextRole(input iwrs_pkg::iwrs_role_e r);
    case (r)
      iwrs_pkg::RO_ADDR: nextRole = iwrs_pkg::RO_PTR;
      iwrs_pkg::RO_PTR: nextRole = iwrs_pkg::RO_HI;
      iwrs_pkg::RO_HI: nextRole = iwrs_pkg::RO_LO;
      default: nextRole = iwrs_pkg::RO_PTR;
    endcase
  endfunction : nextRole

  // Link domain synchronisers
  logic ceL1, ceL2, scl1, scl2, scl3, sda1, sda2, sda3, ack1, ack2, ack3;
  // Sys domain synchronisers
  logic wr1, wr2, wr3, rd1, rd2, rd3;

  iwrs_pkg::iwrs_slv_e st_r, st_nxt;
  iwrs_pkg::iwrs_role_e role_r, role_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt, lo_r, lo_nxt, ptr_r, ptr_nxt, hi_r, hi_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt;
  logic [15:0] wrData_r, wrData_nxt, txWord_r, txWord_nxt;
  logic dir_r, dir_nxt, sdaLow_r, sdaLow_nxt, hiPhase_r, hiPhase_nxt;
  logic nack_r, nack_nxt, wrTgl_r, wrTgl_nxt, rdTgl_r, rdTgl_nxt;
  logic sclRise, sclFall, startDet, stopDet;

  logic [7:0] regAddr_nxt;
  logic [15:0] regWrData_nxt, rdWord_r, rdWord_nxt;
  logic regWe_nxt, regRe_nxt, rdPend_r, rdPend_nxt, rdAck_r, rdAck_nxt;

  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      ceL1 <= 1'b0;
      ceL2 <= 1'b0;
      scl1 <= 1'b1;
      scl2 <= 1'b1;
      scl3 <= 1'b1;
      sda1 <= 1'b1;
      sda2 <= 1'b1;
      sda3 <= 1'b1;
      ack1 <= 1'b0;
      ack2 <= 1'b0;
      ack3 <= 1'b0;
    end else begin
      ceL1 <= ce;
      ceL2 <= ceL1;
      scl1 <= link.scl;
      scl2 <= scl1;
      sda1 <= link.sda;
      sda2 <= sda1;
      ack1 <= rdAck_r;
      ack2 <= ack1;
      if (ceL2) begin
        scl3 <= scl2;
        sda3 <= sda2;
        ack3 <= ack2;
      end
    end
  end

  // Edges are judged on settled copies only, so a glitch is seen at most once
  assign sclRise = scl2 & ~scl3;
  assign sclFall = ~scl2 & scl3;
  assign startDet = scl2 & scl3 & ~sda2 & sda3;
  assign stopDet = scl2 & scl3 & sda2 & ~sda3;

  always_comb begin
    st_nxt = st_r;
    role_nxt = role_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    lo_nxt = lo_r;
    ptr_nxt = ptr_r;
    hi_nxt = hi_r;
    wrAddr_nxt = wrAddr_r;
    wrData_nxt = wrData_r;
    txWord_nxt = txWord_r;
    dir_nxt = dir_r;
    sdaLow_nxt = sdaLow_r;
    hiPhase_nxt = hiPhase_r;
    nack_nxt = nack_r;
    wrTgl_nxt = wrTgl_r;
    rdTgl_nxt = rdTgl_r;
    if (ceL2) begin
      if (ack2 ^ ack3) begin
        txWord_nxt = rdWord_r;
      end
      if (startDet) begin
        // Pointer is left alone so a repeated start reads what was addressed
        st_nxt = iwrs_pkg::SL_RX;
        role_nxt = iwrs_pkg::RO_ADDR;
        cnt_nxt = 4'h0;
        sdaLow_nxt = 1'b0;
      end else if (stopDet) begin
        st_nxt = iwrs_pkg::SL_IDLE;
        sdaLow_nxt = 1'b0;
      end else begin
        case (st_r)
          iwrs_pkg::SL_RX: begin
            if (sclRise && cnt_r != iwrs_pkg::ACK_SLOT) begin
              sh_nxt = {sh_r[6:0], sda2};
              cnt_nxt = cnt_r + 4'h1;
            end else if (sclFall && cnt_r == iwrs_pkg::ACK_SLOT) begin
              cnt_nxt = 4'h0;
              st_nxt = iwrs_pkg::SL_ACKOUT;
              sdaLow_nxt = 1'b1;
              case (role_r)
                iwrs_pkg::RO_ADDR: begin
                  if (sh_r[7:1] == SLAVE_ADDR) begin
                    dir_nxt = sh_r[0];
                    if (sh_r[0] == iwrs_pkg::DIR_RD) begin
                      rdTgl_nxt = ~rdTgl_r;
                    end
                  end else begin
                    st_nxt = iwrs_pkg::SL_IDLE;
                    sdaLow_nxt = 1'b0;
                  end
                end
                iwrs_pkg::RO_PTR: ptr_nxt = sh_r;
                iwrs_pkg::RO_HI: hi_nxt = sh_r;
                default: begin
                  // Word goes out only here, so a cut after the high byte is dropped
                  wrAddr_nxt = ptr_r;
                  wrData_nxt = {hi_r, sh_r};
                  wrTgl_nxt = ~wrTgl_r;
                end
              endcase
            end
          end
          iwrs_pkg::SL_ACKOUT: begin
            if (sclFall) begin
              sdaLow_nxt = 1'b0;
              cnt_nxt = 4'h0;
              if (role_r == iwrs_pkg::RO_ADDR && dir_r == iwrs_pkg::DIR_RD) begin
                st_nxt = iwrs_pkg::SL_TX;
                sh_nxt = txWord_r[15:8];
                lo_nxt = txWord_r[7:0];
                sdaLow_nxt = ~txWord_r[15];
                hiPhase_nxt = 1'b1;
              end else begin
                st_nxt = iwrs_pkg::SL_RX;
                role_nxt = nextRole(role_r);
              end
            end
          end
          iwrs_pkg::SL_TX: begin
            if (sclFall) begin
              if (cnt_r == iwrs_pkg::LAST_DATA_BIT) begin
                sdaLow_nxt = 1'b0;
                st_nxt = iwrs_pkg::SL_ACKIN;
              end else begin
                sh_nxt = {sh_r[6:0], 1'b0};
                sdaLow_nxt = ~sh_r[6];
                cnt_nxt = cnt_r + 4'h1;
              end
            end
          end
          iwrs_pkg::SL_ACKIN: begin
            if (sclRise) begin
              nack_nxt = sda2;
            end else if (sclFall) begin
              cnt_nxt = 4'h0;
              if (nack_r) begin
                st_nxt = iwrs_pkg::SL_IDLE;
              end else begin
                st_nxt = iwrs_pkg::SL_TX;
                if (hiPhase_r) begin
                  // Fetch the next word while the low byte goes out
                  sh_nxt = lo_r;
                  sdaLow_nxt = ~lo_r[7];
                  hiPhase_nxt = 1'b0;
                  rdTgl_nxt = ~rdTgl_r;
                end else begin
                  sh_nxt = txWord_r[15:8];
                  lo_nxt = txWord_r[7:0];
                  sdaLow_nxt = ~txWord_r[15];
                  hiPhase_nxt = 1'b1;
                end
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clkLink or negedge nrst) begin
    if (!nrst) begin
      st_r <= iwrs_pkg::SL_IDLE;
      role_r <= iwrs_pkg::RO_ADDR;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      lo_r <= 8'h00;
      ptr_r <= 8'h00;
      hi_r <= 8'h00;
      wrAddr_r <= 8'h00;
      wrData_r <= 16'h0000;
      txWord_r <= 16'h0000;
      dir_r <= 1'b0;
      sdaLow_r <= 1'b0;
      hiPhase_r <= 1'b0;
      nack_r <= 1'b0;
      wrTgl_r <= 1'b0;
      rdTgl_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      role_r <= role_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      lo_r <= lo_nxt;
      ptr_r <= ptr_nxt;
      hi_r <= hi_nxt;
      wrAddr_r <= wrAddr_nxt;
      wrData_r <= wrData_nxt;
      txWord_r <= txWord_nxt;
      dir_r <= dir_nxt;
      sdaLow_r <= sdaLow_nxt;
      hiPhase_r <= hiPhase_nxt;
      nack_r <= nack_nxt;
      wrTgl_r <= wrTgl_nxt;
      rdTgl_r <= rdTgl_nxt;
    end
  end

  assign link.sdaOutS = 1'b0;
  assign link.sdaOeS = sdaLow_r;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wr1 <= 1'b0;
      wr2 <= 1'b0;
      wr3 <= 1'b0;
      rd1 <= 1'b0;
      rd2 <= 1'b0;
      rd3 <= 1'b0;
    end else begin
      wr1 <= wrTgl_r;
      wr2 <= wr1;
      rd1 <= rdTgl_r;
      rd2 <= rd1;
      if (ce) begin
        wr3 <= wr2;
        rd3 <= rd2;
      end
    end
  end

  // Link-side words stay still for many link cycles after each toggle
  always_comb begin
    regAddr_nxt = regAddr;
    regWrData_nxt = regWrData;
    regWe_nxt = 1'b0;
    regRe_nxt = 1'b0;
    rdPend_nxt = 1'b0;
    rdWord_nxt = rdWord_r;
    rdAck_nxt = rdAck_r;
    if (ce) begin
      if (rdPend_r) begin
        rdWord_nxt = regRdData;
        rdAck_nxt = ~rdAck_r;
      end
      if (wr2 ^ wr3) begin
        regAddr_nxt = wrAddr_r;
        regWrData_nxt = wrData_r;
        regWe_nxt = 1'b1;
      end else if (rd2 ^ rd3) begin
        regAddr_nxt = ptr_r;
        regRe_nxt = 1'b1;
        rdPend_nxt = 1'b1;
      end
    end else begin
      rdPend_nxt = rdPend_r;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      regAddr <= 8'h00;
      regWrData <= 16'h0000;
      regWe <= 1'b0;
      regRe <= 1'b0;
      rdPend_r <= 1'b0;
      rdWord_r <= 16'h0000;
      rdAck_r <= 1'b0;
    end else begin
      regAddr <= regAddr_nxt;
      regWrData <= regWrData_nxt;
      regWe <= regWe_nxt;
      regRe <= regRe_nxt;
      rdPend_r <= rdPend_nxt;
      rdWord_r <= rdWord_nxt;
      rdAck_r <= rdAck_nxt;
    end
  end
endmodule : iwrs_device

// *** core/iwrs_link_if.sv ***
interface iwrs_link_if;
  logic sclOut;
  logic sclOe;
  logic sdaOutM;
  logic sdaOeM;
  logic sdaOutS;
  logic sdaOeS;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = sclOe ? sclOut : 1'b1;
  assign sda = (sdaOeM & ~sdaOutM) | (sdaOeS & ~sdaOutS) ? 1'b0 : 1'b1;

  modport master (output sclOut, output sclOe, output sdaOutM, output sdaOeM,
                  input scl, input sda);
  modport device (output sdaOutS, output sdaOeS, input scl, input sda);
endinterface : iwrs_link_if

// *** core/iwrs_master.sv ***
module iwrs_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic push, pop;

  assign inReady = (wp_r - rp_r) != (AW + 1)'(D);
  assign outValid = wp_r != rp_r;
  assign outData = mem[rp_r[AW-1:0]];
  assign push = ce & inValid & inReady;
  assign pop = ce & outValid & outReady;

  always_comb begin
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= inData;
    end
  end
endmodule : iwrs_fifo

module iwrs_master #(
  parameter logic [6:0] SLAVE_ADDR = iwrs_pkg::DEV_ADDR,
  parameter int QUARTER = iwrs_pkg::QUARTER_CYC,
  parameter int DEPTH = iwrs_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  iwrs_link_if.master link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdRead,
  input wire logic [7:0] cmdReg,
  input wire logic [15:0] cmdData,
  output logic rspValid,
  output logic [15:0] rspData,
  output logic rspNack
);
  // Read: S adrW reg Sr adrR hi lo P. Write: S adrW reg hi lo P.
  function automatic iwrs_pkg::iwrs_mst_e stepKind(input logic [2:0] s, input logic rd);
    if (s == 3'h0 || (rd && s == 3'h3)) stepKind = iwrs_pkg::MS_START;
    else if ((rd && s == 3'h7) || (!rd && s == 3'h5)) stepKind = iwrs_pkg::MS_STOP;
    else stepKind = iwrs_pkg::MS_BIT;
  endfunction : stepKind

  function automatic logic [7:0] stepByte(input logic [2:0] s, input logic [24:0] c);
    case (s)
      3'h1: stepByte = {SLAVE_ADDR, iwrs_pkg::DIR_WR};
      3'h2: stepByte = c[23:16];
      3'h3: stepByte = c[15:8];
      3'h4: stepByte = c[24] ? {SLAVE_ADDR, iwrs_pkg::DIR_RD} : c[7:0];
      default: stepByte = 8'hff;
    endcase
  endfunction : stepByte

  logic [24:0] fData, cmd_r, cmd_nxt;
  logic fValid, fReady, sda1, sda2, tick, isRx;
  iwrs_pkg::iwrs_mst_e st_r, st_nxt;
  logic [2:0] seq_r, seq_nxt;
  logic [1:0] q_r, q_nxt;
  logic [15:0] div_r, div_nxt, rx_r, rx_nxt, rspData_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic sclLow_r, sclLow_nxt, sdaLow_r, sdaLow_nxt, nack_r, nack_nxt;
  logic rspValid_nxt, rspNack_nxt;

  iwrs_fifo #(.W(iwrs_pkg::CMD_W), .D(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ce(ce),
    .inValid(cmdValid),
    .inReady(cmdReady),
    .inData({cmdRead, cmdReg, cmdData}),
    .outValid(fValid),
    .outReady(fReady),
    .outData(fData)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sda1 <= 1'b1;
      sda2 <= 1'b1;
    end else begin
      sda1 <= link.sda;
      sda2 <= sda1;
    end
  end

  assign fReady = st_r == iwrs_pkg::MS_IDLE;
  assign tick = div_r == 16'(QUARTER - 1);
  assign isRx = cmd_r[24] && seq_r >= iwrs_pkg::SEQ_RD_HI;

  always_comb begin
    st_nxt = st_r;
    seq_nxt = seq_r;
    q_nxt = q_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rx_nxt = rx_r;
    cmd_nxt = cmd_r;
    sclLow_nxt = sclLow_r;
    sdaLow_nxt = sdaLow_r;
    nack_nxt = nack_r;
    rspValid_nxt = 1'b0;
    rspNack_nxt = rspNack;
    rspData_nxt = rspData;
    if (ce) begin
      if (st_r == iwrs_pkg::MS_IDLE) begin
        div_nxt = 16'h0000;
        if (fValid) begin
          cmd_nxt = fData;
          st_nxt = iwrs_pkg::MS_START;
          seq_nxt = 3'h0;
          q_nxt = 2'h0;
          nack_nxt = 1'b0;
        end
      end else if (!tick) begin
        div_nxt = div_r + 16'h0001;
      end else begin
        div_nxt = 16'h0000;
        q_nxt = q_r + 2'h1;
        case (st_r)
          iwrs_pkg::MS_START: begin
            case (q_r)
              2'h0: sdaLow_nxt = 1'b0;
              2'h1: sclLow_nxt = 1'b0;
              2'h2: sdaLow_nxt = 1'b1;
              default: sclLow_nxt = 1'b1;
            endcase
          end
          iwrs_pkg::MS_STOP: begin
            case (q_r)
              2'h0: sdaLow_nxt = 1'b1;
              2'h1: sclLow_nxt = 1'b0;
              2'h2: sdaLow_nxt = 1'b0;
              default: begin
                st_nxt = iwrs_pkg::MS_IDLE;
                rspValid_nxt = 1'b1;
                rspNack_nxt = nack_r;
                rspData_nxt = rx_r;
              end
            endcase
          end
          default: begin
            case (q_r)
              2'h0: begin
                if (bit_r == iwrs_pkg::ACK_SLOT) begin
                  sdaLow_nxt = isRx && seq_r != iwrs_pkg::SEQ_RD_LO;
                end else begin
                  sdaLow_nxt = !isRx && !sh_r[7];
                end
              end
              2'h1: sclLow_nxt = 1'b0;
              2'h2: begin
                if (bit_r != iwrs_pkg::ACK_SLOT) begin
                  sh_nxt = {sh_r[6:0], 1'b0};
                  if (isRx) begin
                    rx_nxt = {rx_r[14:0], sda2};
                  end
                end else if (!isRx && sda2) begin
                  nack_nxt = 1'b1;
                end
              end
              default: begin
                sclLow_nxt = 1'b1;
                if (bit_r != iwrs_pkg::ACK_SLOT) begin
                  bit_nxt = bit_r + 4'h1;
                end
              end
            endcase
          end
        endcase
        // Step boundary: a refused byte jumps straight to the stop
        if (q_r == 2'h3 && st_r != iwrs_pkg::MS_STOP &&
            (st_r == iwrs_pkg::MS_START || bit_r == iwrs_pkg::ACK_SLOT)) begin
          bit_nxt = 4'h0;
          seq_nxt = seq_r + 3'h1;
          st_nxt = nack_nxt ? iwrs_pkg::MS_STOP : stepKind(seq_r + 3'h1, cmd_r[24]);
          sh_nxt = stepByte(seq_r + 3'h1, cmd_r);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r <= iwrs_pkg::MS_IDLE;
      seq_r <= 3'h0;
      q_r <= 2'h0;
      div_r <= 16'h0000;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      rx_r <= 16'h0000;
      cmd_r <= '0;
      sclLow_r <= 1'b0;
      sdaLow_r <= 1'b0;
      nack_r <= 1'b0;
      rspValid <= 1'b0;
      rspNack <= 1'b0;
      rspData <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      seq_r <= seq_nxt;
      q_r <= q_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rx_r <= rx_nxt;
      cmd_r <= cmd_nxt;
      sclLow_r <= sclLow_nxt;
      sdaLow_r <= sdaLow_nxt;
      nack_r <= nack_nxt;
      rspValid <= rspValid_nxt;
      rspNack <= rspNack_nxt;
      rspData <= rspData_nxt;
    end
  end

  assign link.sclOut = 1'b0;
  assign link.sclOe = sclLow_r;
  assign link.sdaOutM = 1'b0;
  assign link.sdaOeM = sdaLow_r;
endmodule : iwrs_master

// *** core/iwrs_pkg.sv ***
package iwrs_pkg;
  // Bus address of the device end; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2c;
  localparam int SYS_PERIOD_NS = 40;
  localparam int SCL_PERIOD_NS = 10000;
  // Longest quarter of a serial clock period, rounded down to whole cycles
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
  localparam int FIFO_DEPTH = 32;
  localparam int CMD_W = 25;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic DIR_WR = 1'b0;
  localparam logic DIR_RD = 1'b1;
  localparam logic [2:0] SEQ_RD_HI = 3'h5;
  localparam logic [2:0] SEQ_RD_LO = 3'h6;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_RX = 3'b001,
    SL_ACKOUT = 3'b010,
    SL_TX = 3'b011,
    SL_ACKIN = 3'b100
  } iwrs_slv_e;

  typedef enum logic [1:0] {
    RO_ADDR = 2'b00,
    RO_PTR = 2'b01,
    RO_HI = 2'b10,
    RO_LO = 2'b11
  } iwrs_role_e;

  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_START = 2'b01,
    MS_BIT = 2'b10,
    MS_STOP = 2'b11
  } iwrs_mst_e;
endpackage : iwrs_pkg

// *** tb/iwrs_sva.sv ***
module iwrs_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic sclOe,
  input wire logic sdaOeM,
  input wire logic sdaOeS,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence startSeq;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence stopSeq;
    $rose(sda) && scl && $past(scl);
  endsequence

  chk_dev_sda_stable: assert property (scl && $past(scl) |-> $stable(sdaOeS))
    else $error("device moved data while clock high");
  chk_start_by_master: assert property (startSeq |-> $rose(sdaOeM))
    else $error("start not made by master");
  chk_start_dev_quiet: assert property (startSeq |-> !sdaOeS [*8])
    else $error("device drove data after start");
  chk_stop_dev_idle: assert property (stopSeq |=> !sdaOeS [*8])
    else $error("device drove data after stop");
  chk_ack_clk_low: assert property ($rose(sdaOeS) |-> !scl)
    else $error("device began driving while clock high");
  chk_dev_bit_hold: assert property ($rose(scl) && sdaOeS |-> (sdaOeS && scl) [*6])
    else $error("device bit not held over clock high");
  chk_mst_bit_hold: assert property ($rose(scl) |-> $stable(sdaOeM) [*6])
    else $error("master bit not held over clock high");
  chk_one_driver: assert property (scl |-> !(sdaOeS && sdaOeM))
    else $error("both ends drive data");
  chk_stop_clk_free: assert property (stopSeq |=> !sclOe [*8])
    else $error("clock pulled low right after stop");

  cover property (startSeq);
  cover property (stopSeq);
  cover property ($rose(sdaOeS));
  cover property ($rose(scl) && sdaOeS && !sdaOeM);
endmodule : iwrs_sva

// *** tb/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic clkLink = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic cmdValid = 1'b0;
  logic cmdValid2 = 1'b0;
  logic cmdRead = 1'b0;
  logic [7:0] cmdReg = 8'h00;
  logic [15:0] cmdData = 16'h0000;
  logic cmdReady, cmdReady2, rspValid, rspValid2, rspNack, rspNack2;
  logic regWe, regWe2, regRe, regRe2;
  logic [7:0] regAddr, regAddr2;
  logic [15:0] rspData, rspData2, regWrData, regWrData2, regRdData;
  logic [15:0] devMem [256];
  logic [15:0] refMem [256];
  logic [16:0] expQ [$];
  logic sawFull = 1'b0;
  logic [31:0] seed = 32'ha0ac;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int weCount = 0;
  int we2Count = 0;
  int wrCount = 0;
  int badRsp = 0;
  int reCount = 0;
  int re2Count = 0;
  int rdCount = 0;
  localparam logic [7:0] CREG [4] = '{8'h00, 8'hff, 8'h80, 8'h7f};
  localparam logic [15:0] CDAT [4] = '{16'hffff, 16'h0000, 16'h8001, 16'h7ffe};

  iwrs_link_if link ();
  iwrs_link_if link2 ();

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    #3;
    forever #7.5 clkLink = ~clkLink;
  end

  // Short quarter keeps the run small; the device needs at least 8
  iwrs_master #(.QUARTER(8)) iwrs_master_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .link(link), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdRead(cmdRead),
    .cmdReg(cmdReg), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
    .rspNack(rspNack));
  iwrs_device iwrs_device_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .clkLink(clkLink),
    .link(link), .regAddr(regAddr), .regWe(regWe), .regWrData(regWrData), .regRe(regRe),
    .regRdData(regRdData));
  // Second pair: master calls a foreign address, so the device must stay silent
  iwrs_master #(.SLAVE_ADDR(iwrs_pkg::DEV_ADDR ^ 7'h01), .QUARTER(8)) iwrs_master_bad_inst (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .link(link2), .cmdValid(cmdValid2),
    .cmdReady(cmdReady2), .cmdRead(cmdRead), .cmdReg(cmdReg), .cmdData(cmdData),
    .rspValid(rspValid2), .rspData(), .rspNack(rspNack2));
  iwrs_device iwrs_device_bad_inst (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
    .clkLink(clkLink), .link(link2), .regAddr(regAddr2), .regWe(regWe2),
    .regWrData(regWrData2), .regRe(regRe2), .regRdData(16'h0000));
  iwrs_sva iwrs_sva_inst (.clk_sys(clk_sys), .nrst(nrst), .sclOe(link.sclOe),
    .sdaOeM(link.sdaOeM), .sdaOeS(link.sdaOeS), .scl(link.scl), .sda(link.sda));

  assign regRdData = devMem[regAddr];

  always @(posedge clk_sys) begin
    if (regWe === 1'b1) begin
      devMem[regAddr] <= regWrData;
      weCount <= weCount + 1;
    end
    if (regWe2 === 1'b1) begin
      we2Count <= we2Count + 1;
    end
    if (regRe === 1'b1) begin
      reCount <= reCount + 1;
    end
    if (regRe2 === 1'b1) begin
      re2Count <= re2Count + 1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Register contents both the store and the reference start from
  function automatic logic [15:0] initWord(input int k);
    return 16'(k * 3 + 16'h1200);
  endfunction : initWord

  always @(negedge clk_sys) begin
    logic [16:0] e;
    if (rspValid === 1'b1) begin
      e = expQ.pop_front();
      check(16'(rspNack), 16'h0000);
      if (e[16]) begin
        check(rspData, e[15:0]);
      end
    end
    if (rspValid2 === 1'b1) begin
      badRsp++;
      check(16'(rspNack2), 16'h0001);
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    // Short enable drops stretch both ends in mid-transfer
    ce <= (cycles % 211) > 2;
    if (cycles == 90000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic send(input logic rd, input logic [7:0] ra, input logic [15:0] wd,
                      input logic bad);
    int n;
    n = 0;
    @(posedge clk_sys);
    cmdRead <= rd;
    cmdReg <= ra;
    cmdData <= wd;
    if (bad) cmdValid2 <= 1'b1;
    else cmdValid <= 1'b1;
    @(negedge clk_sys);
    // A command is only taken at an edge where the enable is high too
    while (((bad ? cmdReady2 : cmdReady) !== 1'b1 || ce !== 1'b1) && n < 60000) begin
      if ((bad ? cmdReady2 : cmdReady) !== 1'b1) sawFull = 1'b1;
      @(negedge clk_sys);
      n++;
    end
    if (n >= 60000) num_errors++;
    @(posedge clk_sys);
    cmdValid <= 1'b0;
    cmdValid2 <= 1'b0;
    if (!bad && rd) begin
      expQ.push_back({1'b1, refMem[ra]});
      rdCount++;
    end
    if (!bad && !rd) begin
      expQ.push_back({1'b0, wd});
      refMem[ra] = wd;
      wrCount++;
    end
  endtask : send

  initial begin
    int k;
    for (k = 0; k < 256; k++) begin
      devMem[k] = initWord(k);
      refMem[k] = initWord(k);
    end
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // Boundary pointers and words; reads span a repeated start
    for (k = 0; k < 4; k++) begin
      send(1'b1, CREG[k], 16'h0000, 1'b0);
      send(1'b0, CREG[k], CDAT[k], 1'b0);
      send(1'b1, CREG[k], 16'h0000, 1'b0);
    end
    // Queued far faster than served, so the command buffer fills
    for (k = 0; k < 28; k++) begin
      seed = xs(seed);
      send(seed[0], {4'h0, seed[4:1]}, seed[31:16], 1'b0);
    end
    k = 0;
    while (expQ.size() != 0 && k < 80000) begin
      @(posedge clk_sys);
      k++;
    end
    send(1'b0, 8'h10, 16'h1234, 1'b1);
    send(1'b1, 8'h10, 16'h0000, 1'b1);
    k = 0;
    while (badRsp < 2 && k < 20000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (20) @(posedge clk_sys);
    check(16'(sawFull), 16'h0001);
    check(16'(expQ.size()), 16'h0000);
    check(16'(badRsp), 16'h0002);
    check(16'(weCount), 16'(wrCount));
    check(16'(we2Count), 16'h0000);
    check(16'(reCount), 16'(2 * rdCount));
    check(16'(re2Count), 16'h0000);
    print_verdict();
  end
endmodule : tb_top
